// [mam_pkg.sv]
// ============================================================
// shared constants and types of the memory address map
package mam_pkg;
    // ============================================================
    // widths
    localparam int PC_W = 11;
    localparam int STK_DEPTH = 8;
    localparam int STK_PTR_W = 3;
    localparam int RAM_WORDS = 128;
    localparam int RAM_IDX_W = 7;

    // ============================================================
    // program vectors
    localparam logic [10:0] VEC_RESET = 11'h000;
    localparam logic [10:0] VEC_SOFT = 11'h001;
    localparam logic [10:0] VEC_HARD = 11'h008;

    // ============================================================
    // main space offsets of the registers kept here
    localparam logic [6:0] OFS_INDIRECT_DATA_PORT = 7'h00;
    localparam logic [6:0] OFS_PC_LOW_BYTE = 7'h02;
    localparam logic [6:0] OFS_STATUS_AND_BANK = 7'h03;
    localparam logic [6:0] OFS_INDIRECT_POINTER = 7'h04;
    localparam logic [6:0] OFS_PC_HIGH_BUFFER = 7'h0a;

    // ============================================================
    // main space layout
    localparam logic [6:0] OFS_SFR_LAST = 7'h1f;
    localparam logic [6:0] OFS_RAM_FIRST = 7'h20;
    localparam logic [6:0] OFS_RAM_SHARED = 7'h40;
    localparam logic [6:0] RAM_BANK1_BASE = 7'h60;

    // ============================================================
    // field positions and reset values
    localparam int BANK_HI = 7;
    localparam int BANK_LO = 6;
    localparam int PCHB_HI = 2;
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] POINTER_RST = 8'h00;
    localparam logic [2:0] PCHB_RST = 3'h0;

    // ============================================================
    // types
    typedef enum logic [1:0] {SPC_MAIN, SPC_IOCFG, SPC_SPECIAL} mam_space_t;

    typedef enum logic [3:0] {
        OP_SEQ, OP_SHORT_JUMP, OP_SHORT_CALL, OP_LONG_JUMP, OP_LONG_CALL,
        OP_SUB_EXIT, OP_LIT_EXIT, OP_INT_EXIT, OP_SOFT_INT
    } mam_op_t;

    typedef struct packed {
        logic valid;
        mam_op_t op;
        logic [10:0] target;
    } mam_step_t;

    typedef struct packed {
        logic valid;
        logic write;
        mam_space_t space;
        logic [6:0] addr;
        logic [7:0] wdata;
    } mam_acc_t;

    typedef struct packed {
        logic strobe;
        logic write;
        mam_space_t space;
        logic [4:0] addr;
        logic [7:0] wdata;
    } mam_ext_t;
endpackage

// [mam_stack.sv]
`timescale 1ns/1ns
// ============================================================
// eight-entry circular return stack
module mam_stack
    import mam_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic rst, // async reset
    input wire logic push, // store push_data on top
    input wire logic pop, // drop top entry
    input wire logic [10:0] push_data, // return address
    output logic [10:0] top // current top entry
);
    logic [10:0] entry_reg [STK_DEPTH];
    logic [2:0] ptr_reg;

    // pointer wraps silently in both directions
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ptr_reg <= 3'h0;
        end else if (push) begin
            ptr_reg <= ptr_reg + 3'h1; // RULE25
        end else if (pop) begin
            ptr_reg <= ptr_reg - 3'h1; // RULE25
        end
    end

    // one storage word per level
    genvar i;
    generate
        for (i = 0; i < STK_DEPTH; i++) begin : g_lvl
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    entry_reg[i] <= 11'h000;
                end else if (push && ptr_reg == 3'(i)) begin
                    entry_reg[i] <= push_data; // RULE21
                end
            end
        end
    endgenerate

    // top is the entry below the pointer
    assign top = entry_reg[ptr_reg - 3'h1];
endmodule // mam_stack

// [mam_decode.sv]
`timescale 1ns/1ns
// ============================================================
// data address decode for the three data spaces
module mam_decode
    import mam_pkg::*;
(
    input mam_space_t space, // space of the access
    input wire logic [1:0] bank, // bank select field
    input wire logic [6:0] offset, // offset after indirection
    output logic is_ram, // hits general RAM
    output logic [6:0] ram_idx, // physical RAM word
    output logic is_sfr, // hits a register, not RAM
    output logic [4:0] sfr_addr // register offset
);
    // bank decode and aliasing of the main space
    always_comb begin
        is_ram = 1'b0;
        ram_idx = 7'h00;
        is_sfr = 1'b0;
        sfr_addr = offset[4:0];
        if (space != SPC_MAIN) begin
            is_sfr = 1'b1; // RULE18 RULE19 RULE20
        end else if (offset <= OFS_SFR_LAST) begin
            is_sfr = 1'b1; // RULE13 RULE14
        end else if (offset >= OFS_RAM_SHARED) begin
            is_ram = 1'b1;
            ram_idx = offset - OFS_RAM_FIRST; // RULE16
        end else begin
            is_ram = 1'b1; // RULE15
            // odd banks reach bank 1 cells, even banks bank 0 cells
            if (bank[0]) begin
                ram_idx = RAM_BANK1_BASE + (offset - OFS_RAM_FIRST); // RULE16 RULE24
            end else begin
                ram_idx = offset - OFS_RAM_FIRST; // RULE24
            end
        end
    end
endmodule // mam_decode

// [mam_core.sv]
`timescale 1ns/1ns
// How it works
// [RULE1] program counter is eleven bits wide
// [RULE2] reset loads program counter with zero
// [RULE3] software interrupt jumps to word one
// [RULE4] hardware interrupts share vector word eight
// [RULE5] short jump and call reach 256 words
// [RULE6] long jump and call load full counter
// [RULE7] calls and interrupts push next address first; a hardware interrupt pushes the current address instead
// [RULE8] exit instructions pop top into counter
// [RULE9] software keeps code out of top words
// [RULE10] status bits 7:6 pick one of four banks
// [RULE11] indirect port uses bank and pointer bits
// [RULE12] direct access uses bank and opcode bits
// [RULE13] main registers live only in bank zero
// [RULE14] low offsets in other banks reach bank zero
// [RULE15] RAM exists only in two stated ranges
// [RULE16] missing RAM offsets alias lower banks
// [RULE17] ordinary instructions reach main registers
// [RULE18] config space only through its own instructions
// [RULE19] special space only through its own instructions
// [RULE20] bank field ignored for config and special
// [RULE21] return stack holds eight addresses
// [RULE22] counter advances by one unless written
// [RULE23] counter high bits come from high buffer
// [RULE24] bank values zero to three pick banks
// [RULE25] stack pointer wraps without any error
module mam_core
    import mam_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic rst, // async reset, active high
    input mam_step_t step, // instruction completion from the core
    input wire logic hw_int, // accepted hardware interrupt pulse
    input mam_acc_t acc, // data access from the core
    input wire logic [7:0] ext_rdata, // read data from outside registers
    output logic [10:0] pc, // program counter
    output logic [7:0] rd_data, // read result
    output logic rd_valid, // read result strobe
    output mam_ext_t ext, // access to outside registers
    output logic [1:0] bank_out // current bank select field
);
    // ============================================================
    // state
    logic [10:0] pc_reg;
    logic [10:0] pc_next;
    logic [7:0] status_reg;
    logic [7:0] pointer_reg;
    logic [2:0] pchb_reg;
    logic [7:0] ram_reg [RAM_WORDS];
    logic rd_pend_reg;
    logic rd_ext_reg;
    logic [7:0] rd_int_reg;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;
    mam_ext_t ext_reg;

    // ============================================================
    // stack control
    logic push;
    logic pop;
    logic [10:0] push_data;
    logic [10:0] stk_top;

    mam_stack u_stack (
        .core_clk(core_clk),
        .rst(rst),
        .push(push),
        .pop(pop),
        .push_data(push_data),
        .top(stk_top)
    );

    // ============================================================
    // data address path
    logic [1:0] bank;
    logic indirect;
    logic [6:0] offset;
    logic is_ram;
    logic [6:0] ram_idx;
    logic is_sfr;
    logic [4:0] sfr_addr;
    logic main_sfr;
    logic hit_null;
    logic hit_pcl;
    logic hit_status;
    logic hit_pointer;
    logic hit_pchb;
    logic hit_local;
    logic [7:0] local_rdata;
    logic wr_pcl;
    logic wr_status;
    logic wr_pointer;
    logic wr_pchb;
    logic wr_ram;
    logic [10:0] pc_inc;

    assign bank = status_reg[BANK_HI:BANK_LO]; // RULE10
    assign indirect = acc.space == SPC_MAIN && acc.addr == OFS_INDIRECT_DATA_PORT;
    // indirect port swaps in the pointer, direct takes opcode bits
    assign offset = indirect ? pointer_reg[6:0] : acc.addr; // RULE11 RULE12

    mam_decode u_decode (
        .space(acc.space),
        .bank(bank),
        .offset(offset),
        .is_ram(is_ram),
        .ram_idx(ram_idx),
        .is_sfr(is_sfr),
        .sfr_addr(sfr_addr)
    );

    // valid access to any main-space register offset, local or outside
    assign main_sfr = acc.valid && is_sfr && acc.space == SPC_MAIN; // RULE17

    // one-hot pick of the local register named by the offset
    always_comb begin
        hit_null = 1'b0;
        hit_pcl = 1'b0;
        hit_status = 1'b0;
        hit_pointer = 1'b0;
        hit_pchb = 1'b0;
        if (main_sfr) begin
            case (offset)
                OFS_INDIRECT_DATA_PORT: begin
                    hit_null = 1'b1;
                end
                OFS_PC_LOW_BYTE: begin
                    hit_pcl = 1'b1;
                end
                OFS_STATUS_AND_BANK: begin
                    hit_status = 1'b1;
                end
                OFS_INDIRECT_POINTER: begin
                    hit_pointer = 1'b1;
                end
                OFS_PC_HIGH_BUFFER: begin
                    hit_pchb = 1'b1;
                end
                default: begin
                    hit_null = 1'b0;
                end
            endcase
        end
    end

    // a local register keeps the access off the outside bus
    assign hit_local = hit_null || hit_pcl || hit_status || hit_pointer || hit_pchb;

    // ============================================================
    // write strobes of the local state
    assign wr_pcl = hit_pcl && acc.write;
    assign wr_status = hit_status && acc.write;
    assign wr_pointer = hit_pointer && acc.write;
    assign wr_pchb = hit_pchb && acc.write;
    assign wr_ram = acc.valid && acc.write && is_ram;

    // read mux of local registers and RAM
    always_comb begin
        local_rdata = 8'h00;
        if (hit_pcl) begin
            local_rdata = pc_reg[7:0];
        end else if (hit_status) begin
            local_rdata = status_reg;
        end else if (hit_pointer) begin
            local_rdata = pointer_reg;
        end else if (hit_pchb) begin
            local_rdata = {5'h00, pchb_reg};
        end else if (is_ram) begin
            local_rdata = ram_reg[ram_idx];
        end
    end

    // ============================================================
    // stack requests of the completing instruction
    // address of the word after the current one
    assign pc_inc = pc_reg + 11'h001;

    always_comb begin
        push = 1'b0;
        pop = 1'b0;
        push_data = pc_inc; // RULE7
        if (step.valid) begin
            case (step.op)
                OP_SHORT_CALL, OP_LONG_CALL, OP_SOFT_INT: begin
                    push = 1'b1; // RULE7
                end
                OP_SUB_EXIT, OP_LIT_EXIT, OP_INT_EXIT: begin
                    pop = 1'b1; // RULE8
                end
                default: begin
                    push = 1'b0;
                end
            endcase
        end else if (hw_int) begin
            // interrupted word is fetched again on return
            push = 1'b1; // RULE7
            push_data = pc_reg;
        end
    end

    // ============================================================
    // program flow
    always_comb begin
        pc_next = pc_reg;
        if (step.valid) begin
            case (step.op)
                OP_SEQ: begin
                    pc_next = pc_inc; // RULE22
                end
                OP_SHORT_JUMP, OP_SHORT_CALL: begin
                    pc_next = {3'h0, step.target[7:0]}; // RULE5
                end
                OP_LONG_JUMP, OP_LONG_CALL: begin
                    pc_next = step.target; // RULE6
                end
                OP_SUB_EXIT, OP_LIT_EXIT, OP_INT_EXIT: begin
                    pc_next = stk_top; // RULE8
                end
                OP_SOFT_INT: begin
                    pc_next = VEC_SOFT; // RULE3
                end
                default: begin
                    pc_next = pc_inc;
                end
            endcase
        end else if (hw_int) begin
            pc_next = VEC_HARD; // RULE4
        end
        // writing the low byte replaces the whole counter
        if (wr_pcl) begin
            pc_next = {pchb_reg, acc.wdata}; // RULE23 RULE22
        end
    end

    // program counter
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pc_reg <= VEC_RESET; // RULE2 RULE1
        end else begin
            pc_reg <= pc_next; // RULE1
        end
    end

    // ============================================================
    // local registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_reg <= STATUS_RST;
        end else if (wr_status) begin
            status_reg <= acc.wdata; // RULE10 RULE24
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pointer_reg <= POINTER_RST;
        end else if (wr_pointer) begin
            pointer_reg <= acc.wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pchb_reg <= PCHB_RST;
        end else if (wr_pchb) begin
            pchb_reg <= acc.wdata[PCHB_HI:0]; // RULE23
        end
    end

    // general RAM cells, no reset
    always_ff @(posedge core_clk) begin
        if (wr_ram) begin
            ram_reg[ram_idx] <= acc.wdata; // RULE15 RULE16
        end
    end

    // ============================================================
    // outside register access, one cycle after the request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ext_reg <= '0;
        end else begin
            ext_reg.strobe <= acc.valid && is_sfr && !hit_local; // RULE18 RULE19
            ext_reg.write <= acc.write;
            ext_reg.space <= acc.space;
            ext_reg.addr <= sfr_addr; // RULE20 RULE14
            ext_reg.wdata <= acc.wdata;
        end
    end

    // a read taken now is pending for one cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_pend_reg <= 1'b0;
        end else begin
            rd_pend_reg <= acc.valid && !acc.write; // RULE17
        end
    end

    // remember whether the answer comes from outside
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_ext_reg <= 1'b0;
        end else begin
            rd_ext_reg <= is_sfr && !hit_local;
        end
    end

    // local data is captured in the cycle of the request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_int_reg <= 8'h00;
        end else begin
            rd_int_reg <= local_rdata;
        end
    end

    // answer strobe, one cycle wide, two cycles after the request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_pend_reg;
        end
    end

    // answer data; outside data stands one cycle after its strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= rd_ext_reg ? ext_rdata : rd_int_reg;
        end
    end

    // ============================================================
    // outputs
    assign pc = pc_reg;
    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign ext = ext_reg;
    assign bank_out = status_reg[BANK_HI:BANK_LO];
endmodule // mam_core

// [mam_asserts.sv]
`timescale 1ns/1ns
// ============================================================
// port checker of the address map core
module mam_asserts
    import mam_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic rst, // reset
    input mam_step_t step, // completing instruction
    input wire logic hw_int, // hardware interrupt
    input mam_acc_t acc, // data access
    input wire logic [7:0] ext_rdata, // outside data
    input wire logic [10:0] pc, // counter
    input wire logic [7:0] rd_data, // read result
    input wire logic rd_valid, // read strobe
    input mam_ext_t ext, // outside access
    input wire logic [1:0] bank_out // bank field
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // a data write could overwrite the counter in this cycle
    logic nw;
    assign nw = !(acc.valid && acc.write);

    reset_vec_a:
        assert property ($fell(rst) |-> pc == 11'h000) else $error("pc not at reset vector");
    soft_vec_a:
        assert property (step.valid && step.op == OP_SOFT_INT && nw |=> pc == 11'h001)
            else $error("soft vector wrong");
    hard_vec_a:
        assert property (hw_int && !step.valid && nw |=> pc == 11'h008)
            else $error("hard vector wrong");
    short_reach_a:
        assert property (step.valid && step.op inside {OP_SHORT_JUMP, OP_SHORT_CALL} && nw
            |=> pc == {3'h0, $past(step.target[7:0])}) else $error("short target wrong");
    long_reach_a:
        assert property (step.valid && step.op inside {OP_LONG_JUMP, OP_LONG_CALL} && nw
            |=> pc == $past(step.target)) else $error("long target wrong");
    call_ret_a:
        assert property ((step.valid && step.op == OP_LONG_CALL && nw)
            ##1 (step.valid && step.op == OP_SUB_EXIT && nw) |=> pc == $past(pc, 2) + 11'h001)
            else $error("return address wrong");
    pc_incr_a:
        assert property (step.valid && step.op == OP_SEQ && nw |=> pc == $past(pc) + 11'h001)
            else $error("pc not advanced");
    bank_sel_a:
        assert property (acc.valid && acc.write && acc.space == SPC_MAIN && acc.addr == 7'h03
            |=> bank_out == $past(acc.wdata[7:6])) else $error("bank field not updated");
    page_fwd_a:
        assert property (acc.valid && acc.space != SPC_MAIN |=> ext.strobe
            && ext.space == $past(acc.space) && ext.addr == $past(acc.addr[4:0]))
            else $error("page access not forwarded");
    ram_local_a:
        assert property (acc.valid && acc.space == SPC_MAIN && acc.addr >= 7'h20 |=> !ext.strobe)
            else $error("ram access went outside");
    read_lat_a:
        assert property (acc.valid && !acc.write |-> ##2 rd_valid)
            else $error("read latency wrong");
    ext_read_a:
        assert property (ext.strobe && !ext.write |=> rd_valid && rd_data == $past(ext_rdata))
            else $error("outside data lost");
endmodule // mam_asserts

bind mam_core mam_asserts mam_asserts_inst (.core_clk(core_clk), .rst(rst), .step(step),
    .hw_int(hw_int), .acc(acc), .ext_rdata(ext_rdata), .pc(pc), .rd_data(rd_data),
    .rd_valid(rd_valid), .ext(ext), .bank_out(bank_out));

// [mam_ext_model.sv]
`timescale 1ns/1ns
// ============================================================
// outside register model answering forwarded accesses
module mam_ext_model
    import mam_pkg::*;
(
    input wire logic core_clk, // clock
    input mam_ext_t ext, // forwarded access
    output logic [7:0] ext_rdata // data back to the core
);
    logic [7:0] mem [0:127];
    logic [7:0] last = 8'h00;
    // store writes, remember the last value handed back
    always @(posedge core_clk) begin
        if (ext.strobe && ext.write) begin
            mem[{ext.space, ext.addr}] <= ext.wdata;
        end else if (ext.strobe) begin
            last <= ext_rdata;
        end
    end
    // outside a read the line shows a changed value, so stale data never matches
    assign ext_rdata = (ext.strobe && !ext.write) ? mem[{ext.space, ext.addr}] : ~last;
endmodule // mam_ext_model

// [mam_tb.sv]
`timescale 1ns/1ns
// ============================================================
// self-checking bench of the address map core
module tb;
    import mam_pkg::*;
    logic core_clk, rst, hw_int, rd_valid;
    mam_step_t step;
    mam_acc_t acc;
    mam_ext_t ext;
    logic [7:0] ext_rdata, rd_data;
    logic [10:0] pc, e;
    logic [10:0] r [0:8];
    logic [1:0] bank_out, b;
    int err_count, n_tests;
    // clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    mam_core mam_core_inst (.core_clk(core_clk), .rst(rst), .step(step), .hw_int(hw_int),
        .acc(acc), .ext_rdata(ext_rdata), .pc(pc), .rd_data(rd_data), .rd_valid(rd_valid),
        .ext(ext), .bank_out(bank_out));
    mam_ext_model mam_ext_model_inst (.core_clk(core_clk), .ext(ext), .ext_rdata(ext_rdata));
    // ============================================================
    // compare, close and access tasks (entered at a falling edge)
    task automatic chk(input logic [10:0] got, input logic [10:0] x, input string what);
        n_tests++;
        if (got !== x) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, x);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic stc(input logic v, input mam_op_t op, input logic [10:0] t, input logic irq,
        input logic [10:0] x);
        step = '{v, op, t};
        hw_int = irq;
        // step stays up; the next call or the caller replaces it
        @(negedge core_clk);
        chk(pc, x, "pc");
    endtask
    task automatic xfer(input logic w, input mam_space_t s, input logic [6:0] a,
        input logic [7:0] d);
        acc = '{1'b1, w, s, a, d};
        @(negedge core_clk);
        acc = '0;
        @(negedge core_clk);
    endtask
    task automatic rd(input mam_space_t s, input logic [6:0] a, input logic [7:0] x);
        xfer(1'b0, s, a, 8'h00);
        chk({2'b00, rd_valid, rd_data}, {3'b001, x}, "read");
    endtask
    // hang guard
    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        report_and_stop();
    end
    // ============================================================
    // main sequence
    initial begin
        rst = 1'b1;
        step = '0;
        acc = '0;
        hw_int = 1'b0;
        err_count = 0;
        n_tests = 0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        chk(pc, 11'h000, "reset pc");
        rd(SPC_MAIN, 7'h03, 8'h18);
        stc(1'b1, OP_SEQ, 11'h000, 1'b0, 11'h001);
        stc(1'b1, OP_SEQ, 11'h000, 1'b1, 11'h002);
        stc(1'b1, OP_SOFT_INT, 11'h000, 1'b0, 11'h001);
        stc(1'b1, OP_LIT_EXIT, 11'h000, 1'b0, 11'h003);
        stc(1'b0, OP_SEQ, 11'h000, 1'b1, 11'h008);
        stc(1'b1, OP_INT_EXIT, 11'h000, 1'b0, 11'h003);
        stc(1'b1, OP_SHORT_JUMP, 11'h7ab, 1'b0, 11'h0ab);
        stc(1'b1, OP_SHORT_CALL, 11'h6cd, 1'b0, 11'h0cd);
        stc(1'b1, OP_SUB_EXIT, 11'h000, 1'b0, 11'h0ac);
        stc(1'b1, OP_LONG_JUMP, 11'h7fc, 1'b0, 11'h7fc);
        e = 11'h7fc;
        // nine nested calls overrun the eight entries by one
        for (int i = 0; i < 9; i++) begin
            r[i] = e + 11'h001;
            e = 11'h100 + 11'(i * 33);
            stc(1'b1, OP_LONG_CALL, e, 1'b0, e);
        end
        for (int i = 0; i < 9; i++) begin
            stc(1'b1, OP_SUB_EXIT, 11'h000, 1'b0, r[i < 8 ? 8 - i : 8]);
        end
        step = '0;
        hw_int = 1'b0;
        xfer(1'b1, SPC_MAIN, 7'h25, 8'h5a);
        xfer(1'b1, SPC_MAIN, 7'h65, 8'hc3);
        xfer(1'b1, SPC_MAIN, 7'h03, 8'h58);
        xfer(1'b1, SPC_MAIN, 7'h25, 8'ha5);
        for (int k = 0; k < 4; k++) begin
            b = 2'(k);
            xfer(1'b1, SPC_MAIN, 7'h03, {b, 6'h18});
            chk({9'h000, bank_out}, {9'h000, b}, "bank");
            rd(SPC_MAIN, 7'h25, b[0] ? 8'ha5 : 8'h5a);
            rd(SPC_MAIN, 7'h65, 8'hc3);
            rd(SPC_MAIN, 7'h03, {b, 6'h18});
        end
        xfer(1'b1, SPC_MAIN, 7'h04, 8'h25);
        xfer(1'b1, SPC_MAIN, 7'h00, 8'h3c);
        rd(SPC_MAIN, 7'h00, 8'h3c);
        xfer(1'b1, SPC_MAIN, 7'h05, 8'h77);
        xfer(1'b1, SPC_IOCFG, 7'h05, 8'h11);
        xfer(1'b1, SPC_SPECIAL, 7'h05, 8'h22);
        xfer(1'b1, SPC_MAIN, 7'h03, 8'h18);
        rd(SPC_MAIN, 7'h25, 8'h5a);
        rd(SPC_MAIN, 7'h05, 8'h77);
        rd(SPC_IOCFG, 7'h05, 8'h11);
        rd(SPC_SPECIAL, 7'h05, 8'h22);
        xfer(1'b1, SPC_MAIN, 7'h0a, 8'hfd);
        rd(SPC_MAIN, 7'h0a, 8'h05);
        xfer(1'b1, SPC_MAIN, 7'h02, 8'h34);
        chk(pc, 11'h534, "pc write");
        report_and_stop();
    end
endmodule // tb
